// file: fcsd_host.sv
// Function
// - F0 at any address aborts to read
// - After buffer load, 29 at sector
// - Bypass erase: 80 then 30 or 10
// - Normal sector erase: six writes, four of them unlock
// - B0 anywhere suspends running operation
// - 30 anywhere resumes suspended operation
// - Lock overlay enter AA/55/40; exit 90/0
`timescale 1ns/1ps
`default_nettype none
`include "fcsd_defines.svh"

module fcsd_host
    import fcsd_pkg::*;
#(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 16
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire fcsd_op_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_sector,
    output logic cmd_ready,
    output logic cmd_done,
    output logic [DATA_W-1:0] status_data,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [DATA_W-1:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n
);
    localparam int WP_CYC = `FCSD_CYC(`FCSD_T_WP_NS);
    localparam int WPH_CYC = `FCSD_CYC(`FCSD_T_WPH_NS);
    localparam int RD_CYC = `FCSD_CYC(`FCSD_T_RD_NS);

    // Write table entry: address, data, sector flag
    typedef struct packed {
        logic use_sector;
        logic [11:0] addr;
        logic [7:0] data;
    } fcsd_wr_t;

    function automatic fcsd_wr_t wr(input logic s, input logic [11:0] a,
                                    input logic [7:0] d);
        wr = '{use_sector: s, addr: a, data: d};
    endfunction

    function automatic logic [2:0] seq_len(input fcsd_op_t op);
        case (op)
            FCSD_OP_SECTOR_ERASE: seq_len = 3'h6;
            FCSD_OP_SR_READ: seq_len = 3'h1;
            FCSD_OP_BYPASS_ENTER,
            FCSD_OP_LOCK_ENTER: seq_len = 3'h3;
            FCSD_OP_BYP_SECTOR_ERASE,
            FCSD_OP_BYP_CHIP_ERASE,
            FCSD_OP_BYPASS_EXIT,
            FCSD_OP_LOCK_EXIT: seq_len = 3'h2;
            default: seq_len = 3'h1;
        endcase
    endfunction

    function automatic fcsd_wr_t seq_step(input fcsd_op_t op,
                                          input logic [2:0] i);
        seq_step = wr(1'b0, 12'h000, `FCSD_D_RESET);
        case (op)
            FCSD_OP_CONFIRM:
                seq_step = wr(1'b1, 12'h000, `FCSD_D_CONFIRM);
            FCSD_OP_BYP_SECTOR_ERASE, FCSD_OP_BYP_CHIP_ERASE:
                if (i == 3'h0)
                    seq_step = wr(1'b0, 12'h000, `FCSD_D_ERASE_SETUP);
                else if (op == FCSD_OP_BYP_SECTOR_ERASE)
                    seq_step = wr(1'b1, 12'h000, `FCSD_D_SECTOR_ERASE);
                else
                    seq_step = wr(1'b0, 12'h000, `FCSD_D_CHIP_ERASE);
            FCSD_OP_SECTOR_ERASE:
                case (i)
                    3'h0, 3'h3:
                        seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK1,
                                      `FCSD_D_UNLOCK1);
                    3'h1, 3'h4:
                        seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK2,
                                      `FCSD_D_UNLOCK2);
                    3'h2:
                        seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK1,
                                      `FCSD_D_ERASE_SETUP);
                    default:
                        seq_step = wr(1'b1, 12'h000, `FCSD_D_SECTOR_ERASE);
                endcase
            FCSD_OP_SUSPEND:
                seq_step = wr(1'b0, 12'h000, `FCSD_D_SUSPEND);
            FCSD_OP_RESUME:
                seq_step = wr(1'b0, 12'h000, `FCSD_D_RESUME);
            FCSD_OP_SR_READ:
                seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK1,
                              `FCSD_D_SR_READ);
            FCSD_OP_SR_CLEAR:
                seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK1,
                              `FCSD_D_SR_CLEAR);
            FCSD_OP_BYPASS_ENTER, FCSD_OP_LOCK_ENTER:
                case (i)
                    3'h0:
                        seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK1,
                                      `FCSD_D_UNLOCK1);
                    3'h1:
                        seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK2,
                                      `FCSD_D_UNLOCK2);
                    default:
                        seq_step = wr(1'b0, `FCSD_ADDR_UNLOCK1,
                                      (op == FCSD_OP_LOCK_ENTER) ?
                                      `FCSD_D_LOCK_ENTER :
                                      `FCSD_D_BYPASS_ENTER);
                endcase
            FCSD_OP_BYPASS_EXIT, FCSD_OP_LOCK_EXIT:
                seq_step = wr(1'b0, 12'h000,
                              (i == 3'h0) ? `FCSD_D_EXIT1 : `FCSD_D_EXIT2);
            default:
                seq_step = wr(1'b0, 12'h000, `FCSD_D_RESET);
        endcase
    endfunction

    fcsd_state_t state, next_state;
    fcsd_op_t op, next_op;
    logic [ADDR_W-1:0] sector, next_sector;
    logic [2:0] step, next_step;
    logic [7:0] cnt, next_cnt;
    logic [DATA_W-1:0] dq_s1, dq_s2;
    logic next_cmd_ready, next_cmd_done;
    logic [DATA_W-1:0] next_status_data;
    logic [ADDR_W-1:0] next_flash_addr;
    logic [DATA_W-1:0] next_flash_dq_out;
    logic next_flash_dq_oe, next_flash_ce_n, next_flash_we_n;
    logic next_flash_oe_n;
    fcsd_wr_t cur;

    always_comb
    begin
        cur = seq_step(op, step);
        next_state = state;
        next_op = op;
        next_sector = sector;
        next_step = step;
        next_cnt = cnt;
        next_cmd_ready = 1'b0;
        next_cmd_done = 1'b0;
        next_status_data = status_data;
        next_flash_addr = flash_addr;
        next_flash_dq_out = flash_dq_out;
        next_flash_dq_oe = flash_dq_oe;
        next_flash_ce_n = flash_ce_n;
        next_flash_we_n = 1'b1;
        next_flash_oe_n = 1'b1;
        case (state)
            FCSD_IDLE:
            begin
                next_flash_ce_n = 1'b1;
                next_flash_dq_oe = 1'b0;
                next_cmd_ready = 1'b1;
                if (cmd_valid && cmd_ready)
                begin
                    next_cmd_ready = 1'b0;
                    next_op = cmd_op;
                    next_sector = cmd_sector;
                    next_step = 3'h0;
                    next_state = FCSD_SETUP;
                end
            end
            FCSD_SETUP:
            begin
                // Sector writes use the sector base, else the table address (unlock or zero)
                next_flash_addr = cur.use_sector ? sector :
                                  ADDR_W'(cur.addr);
                next_flash_dq_out = DATA_W'(cur.data);
                next_flash_dq_oe = 1'b1;
                next_flash_ce_n = 1'b0;
                next_flash_we_n = 1'b0;
                next_cnt = 8'(WP_CYC - 1);
                next_state = FCSD_PULSE;
            end
            FCSD_PULSE:
            begin
                next_flash_we_n = 1'b0;
                if (cnt == 8'h00)
                begin
                    next_flash_we_n = 1'b1;
                    next_cnt = 8'(WPH_CYC - 1);
                    next_state = FCSD_RECOVER;
                end
                else
                    next_cnt = cnt - 8'h01;
            end
            FCSD_RECOVER:
            begin
                if (cnt != 8'h00)
                    next_cnt = cnt - 8'h01;
                else if (step + 3'h1 < seq_len(op))
                begin
                    next_step = step + 3'h1;
                    next_state = FCSD_SETUP;
                end
                else if (op == FCSD_OP_SR_READ)
                begin
                    // Second cycle: read at any address
                    next_flash_dq_oe = 1'b0;
                    next_flash_oe_n = 1'b0;
                    next_cnt = 8'(RD_CYC + 1);
                    next_state = FCSD_READ;
                end
                else
                    next_state = FCSD_DONE;
            end
            FCSD_READ:
            begin
                next_flash_oe_n = 1'b0;
                if (cnt == 8'h00)
                begin
                    next_status_data = dq_s2;
                    next_flash_oe_n = 1'b1;
                    next_state = FCSD_DONE;
                end
                else
                    next_cnt = cnt - 8'h01;
            end
            FCSD_DONE:
            begin
                next_flash_ce_n = 1'b1;
                next_flash_dq_oe = 1'b0;
                next_cmd_done = 1'b1;
                next_state = FCSD_IDLE;
            end
            default:
                next_state = FCSD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= FCSD_IDLE;
            op <= FCSD_OP_RESET;
            sector <= '0;
            step <= 3'h0;
            cnt <= 8'h00;
            dq_s1 <= '0;
            dq_s2 <= '0;
            cmd_ready <= 1'b0;
            cmd_done <= 1'b0;
            status_data <= '0;
            flash_addr <= '0;
            flash_dq_out <= '0;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
            sector <= next_sector;
            step <= next_step;
            cnt <= next_cnt;
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
            cmd_ready <= next_cmd_ready;
            cmd_done <= next_cmd_done;
            status_data <= next_status_data;
            flash_addr <= next_flash_addr;
            flash_dq_out <= next_flash_dq_out;
            flash_dq_oe <= next_flash_dq_oe;
            flash_ce_n <= next_flash_ce_n;
            flash_we_n <= next_flash_we_n;
            flash_oe_n <= next_flash_oe_n;
        end
    end
endmodule // fcsd_host

`default_nettype wire

// file: fcsd_defines.svh
`ifndef FCSD_DEFINES_SVH
`define FCSD_DEFINES_SVH

// Unlock addresses
`define FCSD_ADDR_UNLOCK1 12'h555
`define FCSD_ADDR_UNLOCK2 12'h2AA
// Command data codes
`define FCSD_D_UNLOCK1 8'hAA
`define FCSD_D_UNLOCK2 8'h55
`define FCSD_D_RESET 8'hF0
`define FCSD_D_CONFIRM 8'h29
`define FCSD_D_ERASE_SETUP 8'h80
`define FCSD_D_SECTOR_ERASE 8'h30
`define FCSD_D_CHIP_ERASE 8'h10
`define FCSD_D_SUSPEND 8'hB0
`define FCSD_D_RESUME 8'h30
`define FCSD_D_SR_READ 8'h70
`define FCSD_D_SR_CLEAR 8'h71
`define FCSD_D_BYPASS_ENTER 8'h20
`define FCSD_D_EXIT1 8'h90
`define FCSD_D_EXIT2 8'h00
`define FCSD_D_LOCK_ENTER 8'h40
// Bus timing in ns, write pulse, recovery and read access
`define FCSD_T_WP_NS 35
`define FCSD_T_WPH_NS 20
`define FCSD_T_RD_NS 100
`define FCSD_CLK_NS 10
`define FCSD_CYC(ns) (((ns) + `FCSD_CLK_NS - 1) / `FCSD_CLK_NS)

`endif

// file: fcsd_pkg.sv
package fcsd_pkg;
    typedef enum logic [3:0] {
        FCSD_OP_RESET,
        FCSD_OP_CONFIRM,
        FCSD_OP_BYP_SECTOR_ERASE,
        FCSD_OP_BYP_CHIP_ERASE,
        FCSD_OP_SECTOR_ERASE,
        FCSD_OP_SUSPEND,
        FCSD_OP_RESUME,
        FCSD_OP_SR_READ,
        FCSD_OP_SR_CLEAR,
        FCSD_OP_BYPASS_ENTER,
        FCSD_OP_BYPASS_EXIT,
        FCSD_OP_LOCK_ENTER,
        FCSD_OP_LOCK_EXIT
    } fcsd_op_t;

    typedef enum {
        FCSD_IDLE,
        FCSD_SETUP,
        FCSD_PULSE,
        FCSD_RECOVER,
        FCSD_READ,
        FCSD_DONE
    } fcsd_state_t;
endpackage

// file: fcsd_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fcsd_host_chk
    import fcsd_pkg::*;
#(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 16
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire fcsd_op_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_sector,
    input wire logic cmd_ready,
    input wire logic cmd_done,
    input wire logic [DATA_W-1:0] status_data,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic [DATA_W-1:0] flash_dq_in,
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
sequence s_take;
    cmd_valid && cmd_ready;
endsequence
sequence s_we_low;
    !flash_we_n [*3] ##1 flash_we_n;
endsequence
a_take_busy: assert property (s_take |=> !cmd_ready)
    else $error("ready stayed high after take");
a_we_width: assert property ($fell(flash_we_n) |=> s_we_low)
    else $error("write strobe width wrong");
a_write_stable: assert property ((!flash_we_n && !$fell(flash_we_n))
    |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in write");
a_write_drive: assert property (!flash_we_n
    |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
    else $error("write without drive or select");
a_read_float: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives during read");
a_done_pulse: assert property (cmd_done
    |=> !cmd_done && cmd_ready && flash_ce_n)
    else $error("done not a single pulse");
a_busy_bound: assert property ($fell(cmd_ready)
    |-> ##[1:80] cmd_done)
    else $error("sequence never finished");
a_reset_code: assert property ((cmd_valid && cmd_ready
    && cmd_op == FCSD_OP_RESET)
    |-> ##[1:4] (!flash_we_n && flash_dq_out == 16'h00F0))
    else $error("abort code not written");
a_suspend_code: assert property ((cmd_valid && cmd_ready
    && cmd_op == FCSD_OP_SUSPEND)
    |-> ##[1:4] (!flash_we_n && flash_dq_out == 16'h00B0))
    else $error("suspend code not written");
a_high_byte: assert property (flash_dq_oe
    |-> flash_dq_out[DATA_W-1:8] == '0)
    else $error("upper command byte not zero");
endmodule // fcsd_host_chk
bind fcsd_host fcsd_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    u_fcsd_host_chk (.core_clk(core_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sector(cmd_sector),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .status_data(status_data),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n));
`default_nettype wire

// file: fcsd_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcsd_flash_model #(
    parameter int RD_NS = 90,
    parameter logic [15:0] SR_INIT = 16'h00B0
)(
    input wire logic [25:0] flash_addr,
    input wire logic [15:0] dq_wire,
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    output logic [15:0] model_dq
);
logic [25:0] log_a [$];
logic [15:0] log_d [$];
logic [15:0] sr = SR_INIT;
logic sr_rd = 1'b0;
logic [15:0] rd_val;
logic [15:0] prev_d = 16'h0000;
logic lock_open = 1'b0;
int nvr_cycles = 0;
logic [15:0] pre_fill = 16'hFFFF;
// Address and data latched as the write ends
always @(posedge flash_we_n)
begin
    if (!flash_ce_n)
    begin
        log_a.push_back(flash_addr);
        log_d.push_back(dq_wire);
        sr_rd = (dq_wire == 16'h0070);
        if (dq_wire == 16'h0071)
            sr = 16'h0080;
        // Erase start pre-programs every word to zero
        pre_fill = ((dq_wire == 16'h0030 || dq_wire == 16'h0010)
            && (prev_d == 16'h0055 || prev_d == 16'h0080))
            ? 16'h0000 : 16'hFFFF;
        // Register write cycles the whole register array, OTP never
        if (dq_wire == 16'h00F0 || dq_wire == 16'h0090)
            lock_open = 1'b0;
        else if (lock_open)
            nvr_cycles++;
        if (dq_wire == 16'h0040 && flash_addr == 26'h555)
            lock_open = 1'b1;
        prev_d = dq_wire;
    end
end
assign rd_val = sr_rd ? sr : 16'hFFFF;
// Released bus shows the inverse of the read value
assign #(RD_NS) model_dq = (!flash_ce_n && !flash_oe_n) ? rd_val : ~rd_val;
endmodule // fcsd_flash_model
`default_nettype wire

// file: test_flash_command_sequence_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_command_sequence_decoder
    import fcsd_pkg::*;
;
logic core_clk = 1'b0;
logic rst = 1'b1;
logic cmd_valid = 1'b0;
fcsd_op_t cmd_op = FCSD_OP_RESET;
logic [25:0] cmd_sector = 26'h0;
logic cmd_ready, cmd_done, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
logic [15:0] status_data, flash_dq_out, dq_wire, model_dq;
logic [25:0] flash_addr;
int n_fail = 0;
int n_compared = 0;
int cycles = 0;
logic [25:0] exp_a [$];
logic [15:0] exp_d [$];
assign dq_wire = flash_dq_oe ? flash_dq_out : model_dq;
fcsd_host u_fcsd_host (.core_clk(core_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sector(cmd_sector),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .status_data(status_data),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(dq_wire),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n));
fcsd_flash_model u_fcsd_flash_model (.flash_addr(flash_addr),
    .dq_wire(dq_wire), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .model_dq(model_dq));
always #5 core_clk = ~core_clk;
task complete_run;
    if (n_fail == 0 && n_compared > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
always @(posedge core_clk)
begin
    cycles++;
    if (cycles == 20000)
    begin
        n_fail++;
        complete_run();
    end
end
task check_val(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
        n_fail++;
        $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
endtask
task push(input logic [25:0] a, input logic [15:0] d);
    exp_a.push_back(a);
    exp_d.push_back(d);
endtask
task unlock;
    push(26'h555, 16'h00AA);
    push(26'h2AA, 16'h0055);
endtask
// Issue one sequence and compare every bus write
task run_op(input fcsd_op_t op, input logic [25:0] s);
    int base;
    int t;
    base = u_fcsd_flash_model.log_a.size();
    exp_a.delete();
    exp_d.delete();
    case (op)
        FCSD_OP_RESET: push(26'h0, 16'h00F0);
        FCSD_OP_CONFIRM: push(s, 16'h0029);
        FCSD_OP_SUSPEND: push(26'h0, 16'h00B0);
        FCSD_OP_RESUME: push(26'h0, 16'h0030);
        FCSD_OP_SR_READ: push(26'h555, 16'h0070);
        FCSD_OP_SR_CLEAR: push(26'h555, 16'h0071);
        FCSD_OP_BYP_SECTOR_ERASE:
        begin
            push(26'h0, 16'h0080);
            push(s, 16'h0030);
        end
        FCSD_OP_BYP_CHIP_ERASE:
        begin
            push(26'h0, 16'h0080);
            push(26'h0, 16'h0010);
        end
        FCSD_OP_SECTOR_ERASE:
        begin
            unlock();
            push(26'h555, 16'h0080);
            unlock();
            push(s, 16'h0030);
        end
        FCSD_OP_BYPASS_ENTER, FCSD_OP_LOCK_ENTER:
        begin
            unlock();
            push(26'h555, op == FCSD_OP_LOCK_ENTER ? 16'h0040 : 16'h0020);
        end
        default:
        begin
            push(26'h0, 16'h0090);
            push(26'h0, 16'h0000);
        end
    endcase
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_sector <= s;
    t = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && t < 200)
    begin
        @(negedge core_clk);
        t++;
    end
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    t = 0;
    while (cmd_done !== 1'b1 && t < 200)
    begin
        @(negedge core_clk);
        t++;
    end
    check_val("cmd_done", 1, cmd_done);
    t = u_fcsd_flash_model.log_a.size() - base;
    check_val("write count", exp_a.size(), t);
    foreach (exp_a[i])
    begin
        check_val("addr", exp_a[i], u_fcsd_flash_model.log_a[base+i]);
        check_val("data", exp_d[i], u_fcsd_flash_model.log_d[base+i]);
    end
endtask
task test_confirm;
    run_op(FCSD_OP_CONFIRM, 26'h3FE0000);
    run_op(FCSD_OP_CONFIRM, 26'h0020000);
endtask
task test_bypass;
    run_op(FCSD_OP_BYPASS_ENTER, 26'h0);
    run_op(FCSD_OP_BYP_SECTOR_ERASE, 26'h1FE0000);
    check_val("pre_fill", 16'h0000, u_fcsd_flash_model.pre_fill);
    run_op(FCSD_OP_BYP_CHIP_ERASE, 26'h0);
    check_val("pre_fill", 16'h0000, u_fcsd_flash_model.pre_fill);
    run_op(FCSD_OP_BYPASS_EXIT, 26'h0);
endtask
task test_erase_suspend;
    run_op(FCSD_OP_SECTOR_ERASE, 26'h3FE0000);
    check_val("pre_fill", 16'h0000, u_fcsd_flash_model.pre_fill);
    run_op(FCSD_OP_SUSPEND, 26'h0);
    run_op(FCSD_OP_RESUME, 26'h0);
    check_val("pre_fill", 16'hFFFF, u_fcsd_flash_model.pre_fill);
    run_op(FCSD_OP_SUSPEND, 26'h0);
    run_op(FCSD_OP_RESUME, 26'h0);
endtask
task test_status;
    run_op(FCSD_OP_SR_READ, 26'h0);
    check_val("status_data", 16'h00B0, status_data);
    run_op(FCSD_OP_SR_CLEAR, 26'h0);
    run_op(FCSD_OP_SR_READ, 26'h0);
    check_val("status_data", 16'h0080, status_data);
endtask
task test_lock_abort;
    run_op(FCSD_OP_LOCK_ENTER, 26'h0);
    run_op(FCSD_OP_RESET, 26'h0);
    run_op(FCSD_OP_LOCK_ENTER, 26'h0);
    run_op(FCSD_OP_LOCK_EXIT, 26'h0);
    check_val("nvr cycles", 0, u_fcsd_flash_model.nvr_cycles);
endtask
initial
begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    test_confirm();
    test_bypass();
    test_erase_suspend();
    test_status();
    test_lock_abort();
    complete_run();
end
endmodule // test_flash_command_sequence_decoder
`default_nettype wire
